// ---- design/dual_line_serial_control_port.sv ----
`timescale 1ns/1ns
// Behaviour
// - Enable high: each falling serial clock shifts in serial_in, latches kept.
// - Enable low: each falling serial clock loads both channels' detectors.
// - Enable falling edge loads control latches with shift register shifted once more, serial_in entering.
// - Third control bit set energizes ringing relay drive, output low.
// - Fourth control bit set energizes test relay drive, output low.
// - Status nibble: zero-cross, fault, trip, off-hook in positions zero to three.
// - Select bits: 11 active, 10 test, 01 powerdown disconnect on, 00 off.
// - Ringing relay follows its bit regardless of select bits.
// - Test relay follows its bit regardless of other bits.
// - Digital trip stage passes trip detector through one register, same with ringing bit set or clear.
// - Ringing bit set forces that channel's fault flag to zero.
// - Detectors run in powerdown; channels independent.
// - Enable high: serial output shows register MSB, advancing each falling edge.
// - Latches load from serial_in plus first seven shift stages.
// - Serial output can feed next device's input for cascading.
// - Reset leaves all relay drivers off; enable high at power-up.
module dual_line_serial_control_port (
  input wire logic mclk, // 250 MHz core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic serialClk, // Serial clock pin, asynchronous
  input wire logic serialEn, // Enable pin, asynchronous
  input wire logic serial_in, // Serial data pin, asynchronous
  input wire logic [3:0] detA, // Channel A detectors {offhook,trip,fault,zero}
  input wire logic [3:0] detB, // Channel B detectors, same order
  output logic serialOut, // Serial data out
  output logic [7:0] channelControlLatches, // Latched control word
  output dlsc_pkg::dlsc_relay_t relayA, // Channel A relay drivers
  output dlsc_pkg::dlsc_relay_t relayB, // Channel B relay drivers
  output dlsc_pkg::dlsc_state_t stateA, // Channel A state
  output dlsc_pkg::dlsc_state_t stateB // Channel B state
);
  logic [2:0] clkSync_r, clkSync_nxt;
  logic [2:0] enSync_r, enSync_nxt;
  logic [1:0] dinSync_r, dinSync_nxt;
  logic [3:0] detAMeta_r, detASync_r, detBMeta_r, detBSync_r;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic out_r, out_nxt;
  logic clkFall, enFall;
  dlsc_pkg::dlsc_det_t statA, statB;

  always_comb begin
    clkSync_nxt = {clkSync_r[1:0], serialClk};
    enSync_nxt = {enSync_r[1:0], serialEn};
    dinSync_nxt = {dinSync_r[0], serial_in};
  end

  // Stage 0 is read only by stage 1; edges use stages 1 and 2
  assign clkFall = clkSync_r[2] & ~clkSync_r[1];
  assign enFall = enSync_r[2] & ~enSync_r[1];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clkSync_r <= 3'h0;
      enSync_r <= 3'h7;
      dinSync_r <= 2'h0;
      detAMeta_r <= 4'h0;
      detASync_r <= 4'h0;
      detBMeta_r <= 4'h0;
      detBSync_r <= 4'h0;
    end else begin
      clkSync_r <= clkSync_nxt;
      enSync_r <= enSync_nxt;
      dinSync_r <= dinSync_nxt;
      detAMeta_r <= detA;
      detASync_r <= detAMeta_r;
      detBMeta_r <= detB;
      detBSync_r <= detBMeta_r;
    end
  end

  always_comb begin
    shift_nxt = shift_r;
    latch_nxt = latch_r;
    // Enable edge wins regardless of the clock
    if (enFall) begin
      latch_nxt = {shift_r[6:0], dinSync_r[1]};
    end else if (clkFall && enSync_r[2]) begin
      shift_nxt = {shift_r[6:0], dinSync_r[1]};
    end else if (clkFall) begin
      shift_nxt = {statB, statA};
    end
    out_nxt = shift_nxt[7];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= dlsc_pkg::SHIFT_RESET;
      latch_r <= dlsc_pkg::LATCH_RESET;
      out_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      latch_r <= latch_nxt;
      out_r <= out_nxt;
    end
  end

  // Test state with ringing set is the controller's fault; not blocked here
  dlsc_channel chanA (
    .mclk(mclk),
    .rst_b(rst_b),
    .ctrl(latch_r[dlsc_pkg::CH_A_BASE +: dlsc_pkg::CH_BITS]),
    .zeroCrossIn(detASync_r[0]),
    .faultIn(detASync_r[1]),
    .tripIn(detASync_r[2]),
    .offhookIn(detASync_r[3]),
    .status(statA),
    .relay(relayA),
    .state(stateA)
  );

  dlsc_channel chanB (
    .mclk(mclk),
    .rst_b(rst_b),
    .ctrl(latch_r[dlsc_pkg::CH_B_BASE +: dlsc_pkg::CH_BITS]),
    .zeroCrossIn(detBSync_r[0]),
    .faultIn(detBSync_r[1]),
    .tripIn(detBSync_r[2]),
    .offhookIn(detBSync_r[3]),
    .status(statB),
    .relay(relayB),
    .state(stateB)
  );

  assign serialOut = out_r;
  assign channelControlLatches = latch_r;
endmodule

// ---- design/dlsc_pkg.sv ----
package dlsc_pkg;
  localparam int NBITS = 8;
  localparam int CH_BITS = 4;
  // Field positions inside a channel nibble
  localparam int F_SEL_LO = 0;
  localparam int F_SEL_HI = 1;
  localparam int F_RING = 2;
  localparam int F_TEST = 3;
  localparam int CH_A_BASE = 0;
  localparam int CH_B_BASE = 4;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [1:0] SEL_ACTIVE = 2'h3;
  localparam logic [1:0] SEL_TEST = 2'h2;
  localparam logic [1:0] SEL_PD_DISC = 2'h1;
  localparam logic [1:0] SEL_PD = 2'h0;

  typedef enum logic [3:0] {
    ST_PD = 4'h1,
    ST_PD_DISC = 4'h2,
    ST_TEST = 4'h4,
    ST_ACTIVE = 4'h8
  } dlsc_state_t;

  typedef struct packed {
    logic offhookFlag;
    logic tripFlag;
    logic faultFlag;
    logic zeroCrossFlag;
  } dlsc_det_t;

  typedef struct packed {
    logic testRelayDriveN;
    logic ringRelayDriveN;
    logic disconnectRelayDriveN;
  } dlsc_relay_t;
endpackage

// ---- design/dlsc_channel.sv ----
`timescale 1ns/1ns
module dlsc_channel (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [3:0] ctrl, // Latched control nibble
  input wire logic zeroCrossIn, // Synchronised zero-cross detector
  input wire logic faultIn, // Synchronised fault detector
  input wire logic tripIn, // Synchronised raw ring-trip detector
  input wire logic offhookIn, // Synchronised switchhook detector
  output dlsc_pkg::dlsc_det_t status, // Gated detector word
  output dlsc_pkg::dlsc_relay_t relay, // Relay drivers, low energizes
  output dlsc_pkg::dlsc_state_t state // Decoded operating state
);
  dlsc_pkg::dlsc_det_t status_r, status_nxt;
  dlsc_pkg::dlsc_relay_t relay_r, relay_nxt;
  dlsc_pkg::dlsc_state_t state_r, state_nxt;
  logic tripStage_r, tripStage_nxt;
  logic ringBit;

  assign ringBit = ctrl[dlsc_pkg::F_RING];

  always_comb begin
    unique case ({ctrl[dlsc_pkg::F_SEL_HI], ctrl[dlsc_pkg::F_SEL_LO]})
      dlsc_pkg::SEL_ACTIVE: state_nxt = dlsc_pkg::ST_ACTIVE;
      dlsc_pkg::SEL_TEST: state_nxt = dlsc_pkg::ST_TEST;
      dlsc_pkg::SEL_PD_DISC: state_nxt = dlsc_pkg::ST_PD_DISC;
      dlsc_pkg::SEL_PD: state_nxt = dlsc_pkg::ST_PD;
    endcase
    relay_nxt.disconnectRelayDriveN = (state_nxt != dlsc_pkg::ST_PD_DISC);
    relay_nxt.ringRelayDriveN = ~ringBit;
    relay_nxt.testRelayDriveN = ~ctrl[dlsc_pkg::F_TEST];
    // Digital trip stage follows tripIn with or without ringing; the hold term reduces to tripIn
    tripStage_nxt = ringBit ? (tripIn | tripStage_r) & tripIn : tripIn;
    // Detectors keep running in every state, powerdown included
    status_nxt.zeroCrossFlag = zeroCrossIn;
    status_nxt.faultFlag = faultIn & ~ringBit;
    status_nxt.tripFlag = tripStage_r;
    status_nxt.offhookFlag = offhookIn;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dlsc_pkg::ST_PD;
      relay_r <= '1;
      status_r <= '0;
      tripStage_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      relay_r <= relay_nxt;
      status_r <= status_nxt;
      tripStage_r <= tripStage_nxt;
    end
  end

  assign status = status_r;
  assign relay = relay_r;
  assign state = state_r;
endmodule

// ---- tb/dlsc_props.sv ----
`timescale 1ns/1ns
module dlsc_props (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset
  input wire logic serialClk, // pin
  input wire logic serialEn, // pin
  input wire logic serialOut, // pin
  input wire logic [7:0] channelControlLatches, // latches
  input wire dlsc_pkg::dlsc_relay_t relayA, // drivers A
  input wire dlsc_pkg::dlsc_relay_t relayB, // drivers B
  input wire dlsc_pkg::dlsc_state_t stateA, // state A
  input wire dlsc_pkg::dlsc_state_t stateB // state B
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] cl = channelControlLatches;
  ring_drive_a: assert property ({relayA.ringRelayDriveN, relayB.ringRelayDriveN}
    == ~$past({cl[2], cl[6]})) else $error("ring drive wrong");
  test_drive_a: assert property ({relayA.testRelayDriveN, relayB.testRelayDriveN}
    == ~$past({cl[3], cl[7]})) else $error("test drive wrong");
  disc_drive_a: assert property (relayA.disconnectRelayDriveN == ($past(cl[1:0]) != 2'h1)
    && relayB.disconnectRelayDriveN == ($past(cl[5:4]) != 2'h1)) else $error("disc wrong");
  state_a_a: assert property (stateA == 4'(4'h1 << $past(cl[1:0])))
    else $error("state A wrong");
  state_b_a: assert property (stateB == 4'(4'h1 << $past(cl[5:4])))
    else $error("state B wrong");
  latch_hold_a: assert property (!$stable(cl) |-> !$past(serialEn, 2))
    else $error("latch moved");
  shift_out_a: assert property (!$stable(serialOut) |-> !$past(serialClk, 3))
    else $error("out moved");
  reset_off_a: assert property ($rose(rst_b) |-> relayA == 3'h7 && relayB == 3'h7)
    else $error("relay on at reset");
  cover property (stateA == dlsc_pkg::ST_TEST);
  cover property (!relayB.ringRelayDriveN);
  cover property ($fell(serialEn));
endmodule
bind dual_line_serial_control_port dlsc_props chk (.mclk, .rst_b, .serialClk, .serialEn,
  .serialOut, .channelControlLatches, .relayA, .relayB, .stateA, .stateB);

// ---- tb/dlsc_line_ctrl.sv ----
`timescale 1ns/1ns
module dlsc_line_ctrl (
  output logic serialClk, // idles high
  output logic serialEn, // enable
  output logic serialIn, // to device
  input wire logic serialOut // from device
);
  initial begin
    serialClk = 1'b1;
    serialEn = 1'b1;
    serialIn = 1'b0;
  end
  task automatic fall();
    #16 serialClk = 1'b0;
    #16 serialClk = 1'b1;
  endtask
  // Seven shifts; the enable fall takes the last bit straight off the line
  task automatic xfer(input logic [7:0] wr, output logic [7:0] rd);
    for (int i = 7; i >= 1; i--) begin
      rd[i] = serialOut;
      serialIn = wr[i];
      fall();
      #16;
    end
    rd[0] = serialOut;
    serialIn = wr[0];
    #16 serialEn = 1'b0;
    fall();
    serialIn = ~wr[0];
    #16 serialEn = 1'b1;
    #32;
  endtask
endmodule

// ---- tb/dual_line_serial_control_port_tb_top.sv ----
`timescale 1ns/1ns
module dual_line_serial_control_port_tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] detA = 4'h0;
  logic [3:0] detB = 4'h0;
  logic serialClk, serialEn, serialIn, serialOut;
  logic [7:0] latches;
  dlsc_pkg::dlsc_relay_t relayA, relayB;
  dlsc_pkg::dlsc_state_t stateA, stateB;
  int nMismatch = 0;
  int nTests = 0;
  always #2 mclk = ~mclk;
  dual_line_serial_control_port uut (.mclk(mclk), .rst_b(rst_b), .serialClk(serialClk),
    .serialEn(serialEn), .serial_in(serialIn), .detA(detA), .detB(detB),
    .serialOut(serialOut), .channelControlLatches(latches), .relayA(relayA),
    .relayB(relayB), .stateA(stateA), .stateB(stateB));
  dlsc_line_ctrl ctl (.serialClk(serialClk), .serialEn(serialEn), .serialIn(serialIn),
    .serialOut(serialOut));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic completeRun();
    $display("tests %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [3:0] stat(input logic [3:0] d, input logic [3:0] c);
    stat = d;
    if (c[2]) stat[1] = 1'b0;
  endfunction
  function automatic logic [7:0] drv(input logic [3:0] c);
    drv = {5'h0, ~c[3], ~c[2], c[1:0] != 2'h1};
  endfunction
  initial begin
    logic [7:0] wr, rd, expRd;
    logic [7:0] corner [6] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'hcc, 8'hff};
    expRd = 8'h00;
    void'($urandom(85661));
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 46; i++) begin
      wr = (i < 6) ? corner[i] : 8'($urandom);
      if (wr[1:0] == 2'h2) wr[2] = 1'b0;
      if (wr[5:4] == 2'h2) wr[6] = 1'b0;
      @(posedge mclk);
      // Trip stays quiet while ringing, its latching stage is left open
      #1 detA = 4'($urandom) & ~{1'b0, wr[2], 2'h0};
      detB = 4'($urandom) & ~{1'b0, wr[6], 2'h0};
      ctl.xfer(wr, rd);
      chk("status", expRd, rd);
      expRd = {stat(detB, wr[7:4]), stat(detA, wr[3:0])};
      chk("latches", wr, latches);
      chk("relay A", drv(wr[3:0]), 8'(relayA));
      chk("relay B", drv(wr[7:4]), 8'(relayB));
      chk("state A", 8'(4'h1 << wr[1:0]), 8'(stateA));
      chk("state B", 8'(4'h1 << wr[5:4]), 8'(stateB));
    end
    completeRun();
  end
  initial begin
    #100000;
    nMismatch++;
    completeRun();
  end
endmodule
